/* design/hwl_map.svh */
// register offsets, field positions, reset values and limits of the hot water loop block
`ifndef HWL_MAP_SVH
`define HWL_MAP_SVH

`define HWL_CTRL_OFS 8'h00
`define HWL_PGAIN_OFS 8'h04
`define HWL_IGAIN_OFS 8'h08
`define HWL_DGAIN_OFS 8'h0C
`define HWL_OVR_OFS 8'h10
`define HWL_STAT_OFS 8'h14
`define HWL_EFF_OFS 8'h18
`define HWL_ISR_OFS 8'h1C
`define HWL_IMR_OFS 8'h20

`define HWL_CTRL_DERATE_BIT 0
`define HWL_CTRL_MOD_LSB 1
`define HWL_CTRL_MOD_MSB 3
`define HWL_CTRL_DSW_LSB 4
`define HWL_CTRL_DSW_MSB 6

`define HWL_CTRL_RST 7'h00
`define HWL_GAIN_RST 9'h000
`define HWL_OVR_RST 16'h0000
`define HWL_IRQ_RST 2'h0

`define HWL_IRQ_ALERT 0
`define HWL_IRQ_DERATE 1

`define HWL_GAIN_MAX 9'h190
`define HWL_COLD_F 16'shFFD8
`define HWL_FREEZE_F 16'sh0020
`define HWL_SPAN_F 7'h48

`endif

/* design/hwl_pkg.sv */
// types shared by the hot water loop configuration block
package hwl_pkg;

  typedef enum logic [2:0] {
    MOD_INLET = 3'h0,
    MOD_OUTLET = 3'h1,
    MOD_HOT_WATER = 3'h2,
    MOD_AUTO_INLET = 3'h3,
    MOD_AUTO_OUTLET = 3'h4
  } mod_sel_e;

  typedef enum logic [2:0] {
    DSW_NONE = 3'h0,
    DSW_SWITCH = 3'h1,
    DSW_SENSOR = 3'h2,
    DSW_PLATE = 3'h3
  } demand_sw_e;

endpackage

/* design/hwl_override_derate.sv */
// outdoor based derating of the hot water priority override time
`timescale 1ns/1ps
`default_nettype none
`include "hwl_map.svh"

module hwl_override_derate #(
  parameter int TW = 16
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic signed [15:0] i_outdoor_f,
  input wire logic [TW-1:0] i_prog_time,
  output logic [TW-1:0] o_eff_time,
  output logic o_derated
);

  logic signed [16:0] ofs;
  logic [TW+6:0] prod;
  logic [TW+6:0] quot;
  logic [TW-1:0] eff_nxt;

  assign ofs = 17'(i_outdoor_f) - 17'(`HWL_COLD_F);
  assign prod = i_prog_time * ofs[6:0];
  assign quot = prod / (TW+7)'(`HWL_SPAN_F);

  always_comb begin
    // R3 R13: programmed time by default
    eff_nxt = i_prog_time;
    // R2: derate below freezing
    if (i_enable && (i_outdoor_f < `HWL_FREEZE_F)) begin
      // R4: zero at the cold limit
      if (i_outdoor_f <= `HWL_COLD_F) begin
        eff_nxt = '0;
      end else begin
        // R5: linear ramp between limits
        eff_nxt = quot[TW-1:0];
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_eff_time <= '0;
      o_derated <= 1'b0;
    end else begin
      o_eff_time <= eff_nxt;
      o_derated <= i_enable && (i_outdoor_f < `HWL_FREEZE_F);
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  chk_derate_below_freeze: assert property (i_enable && i_outdoor_f < `HWL_FREEZE_F |=> o_derated) // R2
    else $error("derating not flagged below freezing");
  chk_warm_full_time: assert property (i_enable && i_outdoor_f >= `HWL_FREEZE_F |=> o_eff_time == $past(i_prog_time)) // R3
    else $error("override time altered at or above freezing");
  chk_cold_zero_time: assert property (i_enable && i_outdoor_f <= `HWL_COLD_F |=> o_eff_time == '0) // R4
    else $error("override time not zero at cold limit");
  chk_ramp_linear: assert property (i_enable && i_outdoor_f == 16'shFFFC
    |=> o_eff_time == ($past(i_prog_time) >> 1)) // R5
    else $error("midway override time not one half");
  chk_ramp_bounded: assert property (i_enable && i_outdoor_f > `HWL_COLD_F && i_outdoor_f < `HWL_FREEZE_F
    |=> o_eff_time <= $past(i_prog_time)) // R5
    else $error("interpolated time exceeds programmed time");
  chk_disabled_as_is: assert property (!i_enable |=> o_eff_time == $past(i_prog_time) && !o_derated) // R13
    else $error("override time changed with derating disabled");

endmodule // hwl_override_derate

`default_nettype wire

/* design/hwl_config_select.sv */
// hot water loop configuration, derating and modulation source selection with wishbone registers
// What this block does
// R1: holds P, I, D gains of the hot water loop, each zero to four hundred.
// R2: with derating enabled, override time is reduced below thirty-two degrees F.
// R3: derating enabled at or above thirty-two F uses programmed time unchanged.
// R4: derating enabled at or below minus forty F makes override time zero.
// R5: between limits override time scales linearly from zero to full.
// R6: non-temperature modulation source raises alert and suspends hot water control.
// R7: inlet selection takes hot water temperature from the inlet sensor.
// R8: outlet or hot water sensor selection uses that sensor for modulation.
// R9: auto options pick the sensor by demand switch automatic detection.
// R10: auto hot water or inlet uses inlet when input is a switch.
// R11: plate heat exchanger setting enables tap and preheat demand.
// R12: any other setting keeps tap and preheat demand inactive.
// R13: derating disabled uses programmed override time regardless of outdoor temperature.
`timescale 1ns/1ps
`default_nettype none
`include "hwl_map.svh"

module hwl_config_select #(
  parameter int TW = 16,
  parameter int SW = 16
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic signed [15:0] i_outdoor_temp,
  input wire logic [SW-1:0] i_inlet_sensor_input,
  input wire logic i_inlet_is_temp,
  input wire logic [SW-1:0] i_outlet_sensor_input,
  input wire logic i_outlet_is_temp,
  input wire logic [SW-1:0] i_hot_water_sensor_input,
  input wire logic i_hot_water_is_temp,
  input wire logic i_hot_water_switch_input,
  output logic [8:0] o_p_gain,
  output logic [8:0] o_i_gain,
  output logic [8:0] o_d_gain,
  output logic [TW-1:0] o_override_time,
  output logic [SW-1:0] o_mod_temp,
  output logic o_alert,
  output logic o_suspend,
  output logic o_tap_enable,
  output logic o_preheat_enable,
  output logic o_irq
);

  logic derate_en_r;
  hwl_pkg::mod_sel_e mod_sel_r;
  hwl_pkg::demand_sw_e dsw_r;
  logic [TW-1:0] ovr_time_r;
  logic [1:0] isr_r;
  logic [1:0] imr_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic wr;
  logic derated;
  logic derated_d_r;
  logic alert_d_r;
  logic [SW-1:0] mod_nxt;
  logic bad_nxt;
  logic [1:0] isr_nxt;
  // control reset image, seven bits over the derate, modulation and demand switch fields
  localparam logic [6:0] ctrl_rst = `HWL_CTRL_RST;

  // clamp a written gain into the legal range
  function automatic logic [8:0] clamp_gain(input logic [31:0] d);
    clamp_gain = (d > 32'(`HWL_GAIN_MAX)) ? `HWL_GAIN_MAX : d[8:0];
  endfunction

  // write data with byte enables applied over an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        old[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = old;
  endfunction

  // wishbone slave: one wait state, write lands on the ack edge
  assign wr = i_wb_cyc && i_wb_stb && i_wb_we && ack_r;
  assign o_wb_ack = ack_r;
  assign o_wb_dat = rdat_r;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= i_wb_cyc && i_wb_stb && !ack_r;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rdat_r <= 32'h00000000;
    end else if (i_wb_cyc && i_wb_stb && !ack_r) begin
      case (i_wb_adr)
        `HWL_CTRL_OFS: rdat_r <= {25'h0000000, dsw_r, mod_sel_r, derate_en_r};
        `HWL_PGAIN_OFS: rdat_r <= {23'h000000, o_p_gain};
        `HWL_IGAIN_OFS: rdat_r <= {23'h000000, o_i_gain};
        `HWL_DGAIN_OFS: rdat_r <= {23'h000000, o_d_gain};
        `HWL_OVR_OFS: rdat_r <= 32'(ovr_time_r);
        `HWL_STAT_OFS: rdat_r <= {16'(o_mod_temp), 11'h000, derated, o_preheat_enable, o_tap_enable,
                                  o_suspend, o_alert};
        `HWL_EFF_OFS: rdat_r <= 32'(o_override_time);
        `HWL_ISR_OFS: rdat_r <= {30'h00000000, isr_r};
        `HWL_IMR_OFS: rdat_r <= {30'h00000000, imr_r};
        default: rdat_r <= 32'h00000000;
      endcase
    end
  end

  // control register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      derate_en_r <= ctrl_rst[`HWL_CTRL_DERATE_BIT];
      mod_sel_r <= hwl_pkg::MOD_INLET;
      dsw_r <= hwl_pkg::DSW_NONE;
    end else if (wr && i_wb_adr == `HWL_CTRL_OFS && i_wb_sel[0]) begin
      derate_en_r <= i_wb_dat[`HWL_CTRL_DERATE_BIT];
      mod_sel_r <= hwl_pkg::mod_sel_e'(i_wb_dat[`HWL_CTRL_MOD_MSB:`HWL_CTRL_MOD_LSB]);
      dsw_r <= hwl_pkg::demand_sw_e'(i_wb_dat[`HWL_CTRL_DSW_MSB:`HWL_CTRL_DSW_LSB]);
    end
  end

  // R1: gains held and clamped
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_p_gain <= `HWL_GAIN_RST;
      o_i_gain <= `HWL_GAIN_RST;
      o_d_gain <= `HWL_GAIN_RST;
    end else if (wr) begin
      if (i_wb_adr == `HWL_PGAIN_OFS) begin
        o_p_gain <= clamp_gain(merge(32'(o_p_gain), i_wb_dat, i_wb_sel));
      end
      if (i_wb_adr == `HWL_IGAIN_OFS) begin
        o_i_gain <= clamp_gain(merge(32'(o_i_gain), i_wb_dat, i_wb_sel));
      end
      if (i_wb_adr == `HWL_DGAIN_OFS) begin
        o_d_gain <= clamp_gain(merge(32'(o_d_gain), i_wb_dat, i_wb_sel));
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ovr_time_r <= `HWL_OVR_RST;
    end else if (wr && i_wb_adr == `HWL_OVR_OFS) begin
      ovr_time_r <= TW'(merge(32'(ovr_time_r), i_wb_dat, i_wb_sel));
    end
  end

  // R2: derated override time
  hwl_override_derate #(
    .TW(TW)
  ) u_derate (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_enable(derate_en_r),
    .i_outdoor_f(i_outdoor_temp),
    .i_prog_time(ovr_time_r),
    .o_eff_time(o_override_time),
    .o_derated(derated)
  );

  // modulation source selection
  always_comb begin
    mod_nxt = i_inlet_sensor_input;
    bad_nxt = !i_inlet_is_temp;
    case (mod_sel_r)
      // R7: inlet source
      hwl_pkg::MOD_INLET: begin
        mod_nxt = i_inlet_sensor_input;
        bad_nxt = !i_inlet_is_temp;
      end
      // R8: outlet source
      hwl_pkg::MOD_OUTLET: begin
        mod_nxt = i_outlet_sensor_input;
        bad_nxt = !i_outlet_is_temp;
      end
      // R8: hot water sensor
      hwl_pkg::MOD_HOT_WATER: begin
        mod_nxt = i_hot_water_sensor_input;
        bad_nxt = !i_hot_water_is_temp;
      end
      // R9: detection decides between the two
      // R10: switch falls back to inlet
      hwl_pkg::MOD_AUTO_INLET: begin
        if (i_hot_water_switch_input) begin
          mod_nxt = i_inlet_sensor_input;
          bad_nxt = !i_inlet_is_temp;
        end else begin
          mod_nxt = i_hot_water_sensor_input;
          bad_nxt = !i_hot_water_is_temp;
        end
      end
      // R9: automatic detection picks sensor
      hwl_pkg::MOD_AUTO_OUTLET: begin
        if (i_hot_water_switch_input) begin
          mod_nxt = i_outlet_sensor_input;
          bad_nxt = !i_outlet_is_temp;
        end else begin
          mod_nxt = i_hot_water_sensor_input;
          bad_nxt = !i_hot_water_is_temp;
        end
      end
      default: begin
        mod_nxt = '0;
        bad_nxt = 1'b1;
      end
    endcase
  end

  // R6: alert and suspend on a non-temperature source
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_mod_temp <= '0;
      o_alert <= 1'b0;
      o_suspend <= 1'b0;
    end else begin
      o_mod_temp <= bad_nxt ? '0 : mod_nxt;
      o_alert <= bad_nxt;
      o_suspend <= bad_nxt;
    end
  end

  // R11: plate exchanger enables tap and preheat demand
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_tap_enable <= 1'b0;
      o_preheat_enable <= 1'b0;
    end else begin
      // R12: other settings keep them inactive
      o_tap_enable <= (dsw_r == hwl_pkg::DSW_PLATE);
      o_preheat_enable <= (dsw_r == hwl_pkg::DSW_PLATE);
    end
  end

  // sticky events; a new event beats a write-one clear
  always_comb begin
    isr_nxt = isr_r;
    if (wr && i_wb_adr == `HWL_ISR_OFS && i_wb_sel[0]) begin
      isr_nxt = isr_r & ~i_wb_dat[1:0];
    end
    if (o_alert && !alert_d_r) begin
      isr_nxt[`HWL_IRQ_ALERT] = 1'b1;
    end
    if (derated && !derated_d_r) begin
      isr_nxt[`HWL_IRQ_DERATE] = 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      isr_r <= `HWL_IRQ_RST;
      alert_d_r <= 1'b0;
      derated_d_r <= 1'b0;
    end else begin
      isr_r <= isr_nxt;
      alert_d_r <= o_alert;
      derated_d_r <= derated;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      imr_r <= `HWL_IRQ_RST;
    end else if (wr && i_wb_adr == `HWL_IMR_OFS && i_wb_sel[0]) begin
      imr_r <= i_wb_dat[1:0];
    end
  end

  assign o_irq = |(isr_r & imr_r);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  chk_gain_clamp_max: assert property (wr && i_wb_adr == `HWL_PGAIN_OFS && i_wb_sel == 4'hF
    && i_wb_dat > 32'h00000190 |=> o_p_gain == 9'h190) // R1
    else $error("proportional gain not clamped to the maximum");
  chk_gain_write_taken: assert property (wr && i_wb_adr == `HWL_IGAIN_OFS && i_wb_sel == 4'hF
    && i_wb_dat <= 32'h00000190 |=> o_i_gain == $past(i_wb_dat[8:0])) // R1
    else $error("integral gain not taken from the write");
  chk_bad_source_alert: assert property (bad_nxt |=> o_alert && o_suspend && o_mod_temp == '0) // R6
    else $error("non-temperature source did not alert and suspend");
  chk_inlet_selected: assert property (mod_sel_r == hwl_pkg::MOD_INLET && i_inlet_is_temp
    |=> !o_suspend && o_mod_temp == $past(i_inlet_sensor_input)) // R7
    else $error("inlet reading not used");
  chk_outlet_selected: assert property (mod_sel_r == hwl_pkg::MOD_OUTLET && i_outlet_is_temp
    |=> o_mod_temp == $past(i_outlet_sensor_input)) // R8
    else $error("outlet reading not used");
  chk_auto_sensor_kept: assert property (mod_sel_r == hwl_pkg::MOD_AUTO_OUTLET && !i_hot_water_switch_input
    && i_hot_water_is_temp |=> o_mod_temp == $past(i_hot_water_sensor_input)) // R9
    else $error("auto selection ignored the hot water sensor");
  chk_auto_inlet_fallback: assert property (mod_sel_r == hwl_pkg::MOD_AUTO_INLET && i_hot_water_switch_input
    && i_inlet_is_temp |=> o_mod_temp == $past(i_inlet_sensor_input)) // R10
    else $error("switch input did not fall back to inlet");
  chk_plate_enables: assert property (dsw_r == hwl_pkg::DSW_PLATE |=> o_tap_enable && o_preheat_enable) // R11
    else $error("plate exchanger did not enable demand logic");
  chk_plate_inactive: assert property (dsw_r != hwl_pkg::DSW_PLATE |=> !o_tap_enable && !o_preheat_enable) // R12
    else $error("demand logic active without plate exchanger");
  chk_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");

  chk_gain_d_taken: assert property (wr && i_wb_adr == `HWL_DGAIN_OFS && i_wb_sel == 4'hF
    && i_wb_dat <= 32'h00000190 |=> o_d_gain == $past(i_wb_dat[8:0])) // R1
    else $error("differential gain not taken from the write");
  chk_gain_read_back: assert property (o_wb_ack && !i_wb_we && i_wb_adr == `HWL_PGAIN_OFS
    |-> o_wb_dat == {23'h000000, o_p_gain}) // R1
    else $error("proportional gain read back wrong");
  chk_hot_water_selected: assert property (mod_sel_r == hwl_pkg::MOD_HOT_WATER && i_hot_water_is_temp
    |=> o_mod_temp == $past(i_hot_water_sensor_input)) // R8
    else $error("hot water reading not used");
  chk_auto_inlet_sensor: assert property (mod_sel_r == hwl_pkg::MOD_AUTO_INLET && !i_hot_water_switch_input
    && i_hot_water_is_temp |=> o_mod_temp == $past(i_hot_water_sensor_input)) // R9
    else $error("auto inlet option ignored the hot water sensor");
  chk_auto_outlet_fallback: assert property (mod_sel_r == hwl_pkg::MOD_AUTO_OUTLET && i_hot_water_switch_input
    && i_outlet_is_temp |=> o_mod_temp == $past(i_outlet_sensor_input)) // R9
    else $error("switch input did not fall back to outlet");
  chk_alert_event_set: assert property (o_alert && !alert_d_r |=> isr_r[`HWL_IRQ_ALERT])
    else $error("alert event not recorded");
  chk_event_sticky: assert property (isr_r[`HWL_IRQ_ALERT] && !(wr && i_wb_adr == `HWL_ISR_OFS && i_wb_sel[0]
    && i_wb_dat[`HWL_IRQ_ALERT]) |=> isr_r[`HWL_IRQ_ALERT])
    else $error("alert status lost without a clear");
  chk_ack_answers: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not acknowledged after one cycle");

  cov_auto_fallback: cover property (mod_sel_r == hwl_pkg::MOD_AUTO_INLET && i_hot_water_switch_input ##1 !o_suspend);
  cov_alert_irq: cover property (o_alert && !alert_d_r ##1 o_irq);
  cov_derated: cover property (derate_en_r && derated ##1 o_override_time < ovr_time_r);
  cov_plate: cover property (o_tap_enable ##1 !o_tap_enable);
  cov_suspend_cleared: cover property (o_suspend ##1 !o_suspend);

endmodule // hwl_config_select

`default_nettype wire

/* tb/hwl_sensor_model.sv */
// sensor and operator setting source in front of the hot water loop block
`timescale 1ns/1ps
`default_nettype none
module hwl_sensor_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic signed [15:0] i_outdoor_set,
  input wire logic [2:0] i_is_temp_set,
  input wire logic i_switch_set,
  output logic signed [15:0] o_outdoor,
  output logic [15:0] o_inlet,
  output logic [15:0] o_outlet,
  output logic [15:0] o_hot_water,
  output logic [2:0] o_is_temp,
  output logic o_switch
);
  // a non-temperature input shows a reading that moves every cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_outdoor <= 16'sh0040;
      o_inlet <= 16'h0111;
      o_outlet <= 16'h0222;
      o_hot_water <= 16'h0333;
      o_is_temp <= 3'h7;
      o_switch <= 1'b0;
    end else begin
      o_outdoor <= i_outdoor_set;
      o_inlet <= i_is_temp_set[0] ? 16'h0111 : o_inlet + 16'h1357;
      o_outlet <= i_is_temp_set[1] ? 16'h0222 : o_outlet + 16'h1357;
      o_hot_water <= i_is_temp_set[2] ? 16'h0333 : o_hot_water + 16'h1357;
      o_is_temp <= i_is_temp_set;
      o_switch <= i_switch_set;
    end
  end
endmodule // hwl_sensor_model
`default_nettype wire

/* tb/hot_water_loop_config_select_bench.sv */
// self-checking bench of the hot water loop configuration block
`timescale 1ns/1ps
`default_nettype none
`include "hwl_map.svh"
module hot_water_loop_config_select_bench;
  logic clock = 0, rst = 1, cyc = 0, stb = 0, we = 0, sw_set = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rd, wb_dat;
  logic signed [15:0] out_set = 16'sh0040, outdoor;
  logic [2:0] temp_set = 3'h7, is_temp;
  logic [15:0] inlet, outlet, hot_water, mod_temp, ovr;
  logic [8:0] p_gain, i_gain, d_gain;
  logic ack, sw, alert, suspend, tap, preheat, irq;
  int mismatches = 0, checked = 0, cycles = 0;
  initial forever #12.5 clock = ~clock;
  hwl_sensor_model i_hwl_sensor_model (.i_clock(clock), .i_rst(rst), .i_outdoor_set(out_set),
    .i_is_temp_set(temp_set), .i_switch_set(sw_set), .o_outdoor(outdoor), .o_inlet(inlet),
    .o_outlet(outlet), .o_hot_water(hot_water), .o_is_temp(is_temp), .o_switch(sw));
  hwl_config_select #(.TW(16), .SW(16)) i_hwl_config_select (.i_clock(clock), .i_rst(rst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(wb_dat), .o_wb_ack(ack), .i_outdoor_temp(outdoor), .i_inlet_sensor_input(inlet),
    .i_inlet_is_temp(is_temp[0]), .i_outlet_sensor_input(outlet), .i_outlet_is_temp(is_temp[1]),
    .i_hot_water_sensor_input(hot_water), .i_hot_water_is_temp(is_temp[2]),
    .i_hot_water_switch_input(sw), .o_p_gain(p_gain), .o_i_gain(i_gain), .o_d_gain(d_gain),
    .o_override_time(ovr), .o_mod_temp(mod_temp), .o_alert(alert), .o_suspend(suspend),
    .o_tap_enable(tap), .o_preheat_enable(preheat), .o_irq(irq));
  task automatic end_of_test();
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do @(posedge clock); while (ack !== 1'b1);
    rd = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask
  function automatic logic [31:0] ctrl(input logic der, input logic [2:0] m, input logic [2:0] d);
    return {25'h0, d, m, der};
  endfunction
  function automatic logic [15:0] exp_ovr(input int t, input int p);
    if (t >= 32) return p[15:0];
    if (t <= -40) return 16'h0000;
    return 16'((p * (t + 40)) / 72);
  endfunction
  int temps[8] = '{32, 100, 31, -4, -39, -40, -50, 0};
  logic [15:0] expv[5];
  initial begin
    tick(6);
    rst <= 1'b0;
    tick(1);
    wb_io(1'b1, `HWL_PGAIN_OFS, 32'h0000_0191);
    wb_io(1'b1, `HWL_IGAIN_OFS, 32'h0000_0190);
    wb_io(1'b1, `HWL_DGAIN_OFS, 32'h0000_007B);
    tick(2);
    check("p gain", p_gain, 32'h190);
    check("i gain", i_gain, 32'h190);
    check("d gain", d_gain, 32'h07B);
    wb_io(1'b0, `HWL_PGAIN_OFS, 32'h0);
    check("p gain read", rd, 32'h190);
    wb_io(1'b0, 8'h40, 32'h0);
    check("unmapped read", rd, 32'h0);
    wb_io(1'b1, `HWL_OVR_OFS, 32'h0000_0120);
    wb_io(1'b1, `HWL_CTRL_OFS, ctrl(1'b1, 3'h0, 3'h0));
    foreach (temps[k]) begin
      out_set <= 16'(temps[k]);
      tick(4);
      check("override", ovr, exp_ovr(temps[k], 288));
    end
    wb_io(1'b0, `HWL_EFF_OFS, 32'h0);
    check("override read", rd, 32'h00A0);
    out_set <= -16'sd50;
    wb_io(1'b1, `HWL_CTRL_OFS, ctrl(1'b0, 3'h0, 3'h0));
    tick(4);
    check("override off", ovr, 32'h0120);
    expv = '{16'h0111, 16'h0222, 16'h0333, 16'h0111, 16'h0222};
    for (int m = 0; m < 5; m++) begin
      sw_set <= 1'b1;
      wb_io(1'b1, `HWL_CTRL_OFS, ctrl(1'b0, 3'(m), 3'h0));
      tick(4);
      check("mod temp", mod_temp, expv[m]);
      check("alert", alert, 1'b0);
      sw_set <= 1'b0;
      tick(4);
      check("mod temp auto", mod_temp, m > 2 ? 16'h0333 : expv[m]);
    end
    for (int d = 0; d < 4; d++) begin
      wb_io(1'b1, `HWL_CTRL_OFS, ctrl(1'b0, 3'h0, 3'(d)));
      tick(2);
      check("tap", tap, d == 3);
      check("preheat", preheat, d == 3);
    end
    wb_io(1'b1, `HWL_ISR_OFS, 32'h3);
    wb_io(1'b1, `HWL_IMR_OFS, 32'h1);
    temp_set <= 3'h6;
    tick(4);
    check("alert on", alert, 1'b1);
    check("suspend on", suspend, 1'b1);
    check("mod temp off", mod_temp, 32'h0);
    check("irq on", irq, 1'b1);
    temp_set <= 3'h7;
    tick(4);
    check("alert off", alert, 1'b0);
    check("irq sticky", irq, 1'b1);
    wb_io(1'b1, `HWL_ISR_OFS, 32'h1);
    tick(1);
    check("irq cleared", irq, 1'b0);
    wb_io(1'b1, `HWL_IMR_OFS, 32'h0);
    temp_set <= 3'h5;
    wb_io(1'b1, `HWL_CTRL_OFS, ctrl(1'b0, 3'h1, 3'h0));
    tick(4);
    check("alert outlet", alert, 1'b1);
    check("irq masked", irq, 1'b0);
    wb_io(1'b0, `HWL_STAT_OFS, 32'h0);
    check("status read", rd, 32'h0000_0003);
    wb_io(1'b0, `HWL_ISR_OFS, 32'h0);
    check("status sticky", rd[0], 1'b1);
    end_of_test();
  end
endmodule // hot_water_loop_config_select_bench
`default_nettype wire
